/* verilog/spi_eeprom_pkg.sv */
// Purpose: shared constants and types for the eeprom reset/init block
// Assumes: 200 MHz system clock, serial pins synchronous to it
// Notes: status layout is fixed by the packed struct below
package spi_eeprom_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLOCK_MHZ = 200;
    // least time the master waits after supply is stable, in microseconds
    localparam int POWERUP_WAIT_US = 100;
    // least time, whole microseconds at whole MHz: exact, no rounding
    localparam int POWERUP_WAIT_CYCLES = POWERUP_WAIT_US * CLOCK_MHZ;
    localparam int WAIT_COUNT_BITS = 16;

    ////////////////////////////////////////////////////////////////////////
    // factory and reset values
    localparam logic [7:0] FACTORY_ARRAY_BYTE = 8'hff;
    localparam logic [1:0] FACTORY_BLOCK_PROTECT = 2'h0;
    localparam logic [3:0] STATUS_UNUSED_VALUE = 4'h0;
    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
    localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
    localparam logic [7:0] TX_RESET_VALUE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // types
    // bit 7..4 unused, 3 protect hi, 2 protect lo, 1 latch, 0 busy
    typedef struct packed {
        logic [3:0] unused;
        logic block_protect_hi;
        logic block_protect_lo;
        logic write_enable_latch;
        logic ready_busy_flag;
    } status_t;

    // one received byte; first marks the opcode of a transfer
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } rx_byte_t;

    typedef enum logic [1:0] {
        por_wait,
        standby,
        selected,
        paused
    } iface_state_t;

endpackage : spi_eeprom_pkg

/* verilog/nv_protect_store.sv */
// Purpose: nonvolatile store for the two block-protect bits
// Assumes: storage keeps its content across resetn
// Notes: no reset on purpose; starts at the factory value
`timescale 1ns/1ps
module nv_protect_store (
    input wire logic clock,
    input wire logic write_strobe,
    input wire logic [1:0] write_data,
    output logic [1:0] bits
);

    // RULE9 factory protect value
    logic [1:0] cells = spi_eeprom_pkg::FACTORY_BLOCK_PROTECT;

    // RULE7 untouched by reset
    always_ff @(posedge clock) begin
        if (write_strobe) begin
            cells <= write_data;
        end
    end

    assign bits = cells;

endmodule : nv_protect_store

/* verilog/spi_eeprom_reset_init.sv */
// Purpose: power-up and serial interface reset logic of an spi eeprom slave
// Assumes: resetn is the power-on reset; pins sampled on clock
// Notes: opcode decode and array writes live outside this block
//
// Overview of operation
// RULE1: ignore instructions until power-on reset releases
// RULE2: master waits 100 us before first instruction
// RULE3: master toggles select without clocks to reset
// RULE4: clockless toggle abandons partial transfer, new opcode
// RULE5: power-up: latch clear, standby, deselected, unpaused
// RULE6: power-up ready/busy flag reads zero
// RULE7: block-protect bits survive power-on reset
// RULE8: factory array bytes all FFh
// RULE9: factory block-protect bits both zero
// RULE10: status bits 3..0 protect, latch, busy
// RULE11: selected only while select low; else tristate
// RULE12: interface reset clears receiver, keeps status; a deselect while paused clears the latch
`timescale 1ns/1ps
module spi_eeprom_reset_init #(
    parameter int powerup_wait_cycles = spi_eeprom_pkg::POWERUP_WAIT_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic write_busy,
    input wire logic wel_set,
    input wire logic wel_clear,
    input wire logic bp_write,
    input wire logic [1:0] bp_wdata,
    input wire logic tx_load,
    input wire logic [7:0] tx_byte,
    output logic so,
    output logic so_oe,
    output spi_eeprom_pkg::rx_byte_t rx_byte,
    output logic rx_valid,
    output spi_eeprom_pkg::status_t status,
    output logic standby,
    output logic selected,
    output logic paused,
    output logic iface_reset,
    output logic powerup_wait_elapsed,
    output logic [7:0] erased_value
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    spi_eeprom_pkg::iface_state_t state;
    logic sck_q;
    logic sck_rise;
    logic sck_fall;
    logic clocks_seen;
    logic in_frame;
    logic shift_en;
    logic [2:0] bit_count;
    logic [6:0] shift;
    logic first_byte;
    logic write_enable_latch;
    logic ready_busy_flag;
    logic [1:0] bp_bits;
    logic [7:0] tx_shift;
    logic tx_active;
    logic [spi_eeprom_pkg::WAIT_COUNT_BITS-1:0] wait_count;
    logic seen_cycle;

    ////////////////////////////////////////////////////////////////////////
    // serial clock edge detect
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
        end
    end

    assign sck_rise = sck & ~sck_q;
    assign sck_fall = ~sck & sck_q;
    assign in_frame = (state == spi_eeprom_pkg::selected) ||
                      (state == spi_eeprom_pkg::paused);
    assign shift_en = (state == spi_eeprom_pkg::selected) & sck_rise;

    ////////////////////////////////////////////////////////////////////////
    // interface state
    // RULE1 hold off until released
    // RULE5 start deselected, unpaused
    // RULE11 select follows low chip select
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= spi_eeprom_pkg::por_wait;
        end else begin
            case (state)
                spi_eeprom_pkg::por_wait: begin
                    // a select already low at release is not a frame
                    if (cs_n) begin
                        state <= spi_eeprom_pkg::standby;
                    end
                end
                spi_eeprom_pkg::standby: begin
                    if (!cs_n) begin
                        state <= spi_eeprom_pkg::selected;
                    end
                end
                spi_eeprom_pkg::selected: begin
                    if (cs_n) begin
                        state <= spi_eeprom_pkg::standby;
                    end else if (!hold_n && !sck) begin
                        state <= spi_eeprom_pkg::paused;
                    end
                end
                spi_eeprom_pkg::paused: begin
                    if (cs_n) begin
                        state <= spi_eeprom_pkg::standby;
                    end else if (hold_n && !sck) begin
                        state <= spi_eeprom_pkg::selected;
                    end
                end
                default: begin
                    state <= spi_eeprom_pkg::por_wait;
                end
            endcase
        end
    end

    assign standby = (state == spi_eeprom_pkg::standby);
    assign selected = (state == spi_eeprom_pkg::selected);
    assign paused = (state == spi_eeprom_pkg::paused);

    ////////////////////////////////////////////////////////////////////////
    // clockless select toggle detect
    // RULE4 select without clocks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clocks_seen <= 1'b0;
            iface_reset <= 1'b0;
        end else begin
            if (!in_frame) begin
                clocks_seen <= 1'b0;
            end else if (shift_en) begin
                clocks_seen <= 1'b1;
            end
            iface_reset <= in_frame & cs_n & ~clocks_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver: opcode, address and data bits, msb first
    // RULE4 drop partial byte
    // RULE12 receiver back to idle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_count <= spi_eeprom_pkg::BIT_COUNT_RESET;
            shift <= 7'h00;
            first_byte <= 1'b1;
        end else if (!in_frame) begin
            bit_count <= spi_eeprom_pkg::BIT_COUNT_RESET;
            first_byte <= 1'b1;
        end else if (shift_en) begin
            shift <= {shift[5:0], si};
            bit_count <= 3'(bit_count + 3'h1);
            if (bit_count == spi_eeprom_pkg::BIT_COUNT_LAST) begin
                first_byte <= 1'b0;
            end
        end
    end

    // completed byte out, one-cycle strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_valid <= 1'b0;
            rx_byte <= '0;
        end else begin
            rx_valid <= shift_en &&
                        (bit_count == spi_eeprom_pkg::BIT_COUNT_LAST);
            if (shift_en && (bit_count == spi_eeprom_pkg::BIT_COUNT_LAST))
            begin
                rx_byte <= '{first: first_byte, data: {shift, si}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write enable latch
    // RULE5 latch clear at power-up
    // RULE12 untouched by select toggle unless paused
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            write_enable_latch <= 1'b0;
        end else if (wel_set) begin
            // set wins over a clear in the same cycle
            write_enable_latch <= 1'b1;
        end else if (wel_clear || (paused && cs_n)) begin
            // deselect while paused aborts and drops the latch
            write_enable_latch <= 1'b0;
        end
    end

    // RULE6 ready at power-up
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ready_busy_flag <= 1'b0;
        end else begin
            ready_busy_flag <= write_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile protect bits, written only with the latch set
    // RULE7 kept outside reset
    nv_protect_store protect_store (
        .clock(clock),
        .write_strobe(bp_write & write_enable_latch),
        .write_data(bp_wdata),
        .bits(bp_bits)
    );

    // RULE10 status layout
    assign status = '{unused: spi_eeprom_pkg::STATUS_UNUSED_VALUE,
                      block_protect_hi: bp_bits[1],
                      block_protect_lo: bp_bits[0],
                      write_enable_latch: write_enable_latch,
                      ready_busy_flag: ready_busy_flag};

    ////////////////////////////////////////////////////////////////////////
    // transmitter: shifts on falling serial clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_shift <= spi_eeprom_pkg::TX_RESET_VALUE;
            tx_active <= 1'b0;
        end else if (!in_frame) begin
            tx_active <= 1'b0;
        end else if (tx_load) begin
            tx_shift <= tx_byte;
            tx_active <= 1'b1;
        end else if (selected && sck_fall && tx_active) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    // RULE11 tristate unless selected
    assign so = tx_shift[7];
    assign so_oe = tx_active & selected;

    ////////////////////////////////////////////////////////////////////////
    // power-up wait indicator, saturates
    // RULE2 master wait window
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_count <= '0;
            powerup_wait_elapsed <= 1'b0;
        end else if (!powerup_wait_elapsed) begin
            wait_count <= spi_eeprom_pkg::WAIT_COUNT_BITS'(wait_count + 1'b1);
            powerup_wait_elapsed <= (wait_count ==
                spi_eeprom_pkg::WAIT_COUNT_BITS'(powerup_wait_cycles - 1));
        end
    end

    // RULE8 erased byte value
    assign erased_value = spi_eeprom_pkg::FACTORY_ARRAY_BYTE;

    ////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            seen_cycle <= 1'b0;
        end else begin
            seen_cycle <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    por_ignore_a: assert property ( // RULE1
        (state == spi_eeprom_pkg::por_wait) |=> !rx_valid && !so_oe)
        else $error("activity before power-on release");
    reset_default_a: assert property ( // RULE5
        !seen_cycle |-> !status.write_enable_latch && !selected && !paused)
        else $error("wrong default state after reset");
    busy_default_a: assert property ( // RULE6
        !seen_cycle |-> !status.ready_busy_flag)
        else $error("busy flag set after reset");
    toggle_abandon_a: assert property ( // RULE4
        iface_reset |=> (bit_count == 3'h0) && first_byte && !rx_valid)
        else $error("partial transfer kept after select toggle");
    toggle_status_a: assert property ( // RULE12
        iface_reset && !wel_set && !wel_clear && !bp_write
        |=> $stable(status))
        else $error("status changed by select toggle");
    protect_keep_a: assert property ( // RULE7
        !bp_write |=> $stable(bp_bits))
        else $error("protect bits changed without a write");
    status_layout_a: assert property ( // RULE10
        status[3:2] == bp_bits && status[7:4] == 4'h0 &&
        status[1] == write_enable_latch)
        else $error("status layout wrong");
    deselect_quiet_a: assert property ( // RULE11
        cs_n && $past(cs_n) |-> !so_oe ##1 !rx_valid)
        else $error("drive or input while deselected");
    pause_quiet_a: assert property ( // RULE11
        paused && $past(paused) |-> !so_oe && !rx_valid)
        else $error("activity while paused");

    toggle_seen_c: cover property (iface_reset);
    opcode_seen_c: cover property (rx_valid && rx_byte.first);
    pause_seen_c: cover property (paused ##1 selected);
    wait_seen_c: cover property ($rose(powerup_wait_elapsed));

endmodule : spi_eeprom_reset_init

/* tb/spi_master_model.sv */
// Purpose: behavioural spi bus master driving the eeprom pins
// Assumes: mode 0, pins change just after a clock rise
// Notes: every sck level is held for two clock samples
`timescale 1ns/1ps
module spi_master_model (
    input wire logic clock,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    // idle pins at time zero
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // set chip select, then let two samples pass
    task automatic drive_cs(input logic v);
        @(posedge clock) cs_n <= v;
        repeat (2) @(posedge clock);
    endtask : drive_cs

    // shift n bits of b, msb first, data set while sck low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock) si <= b[7 - i];
            @(posedge clock) sck <= 1'b1;
            @(posedge clock);
            @(posedge clock) sck <= 1'b0;
        end
        // stale data line never shows the last bit
        @(posedge clock) si <= ~si;
    endtask : send_bits

    task automatic toggle_reset();
        drive_cs(1'b1);
        drive_cs(1'b0);
        drive_cs(1'b1);
    endtask : toggle_reset

    // pause request level, sck stays low
    task automatic set_hold(input logic v);
        @(posedge clock) hold_n <= v;
        repeat (2) @(posedge clock);
    endtask : set_hold
endmodule : spi_master_model

/* tb/spi_eeprom_reset_init_tb.sv */
// Purpose: self-checking bench for the eeprom reset and init block
// Assumes: master model drives the serial pins, bench the strobes
// Notes: power-up wait shortened to 8 cycles
`timescale 1ns/1ps
module spi_eeprom_reset_init_tb;
    logic clock, resetn, cs_n, sck, si, hold_n, write_busy;
    logic wel_set, wel_clear, bp_write, tx_load, so, so_oe, rx_valid;
    logic standby, selected, paused, iface_reset, powerup_wait_elapsed;
    logic [1:0] bp_wdata;
    logic [7:0] tx_byte, erased_value;
    spi_eeprom_pkg::rx_byte_t rx_byte;
    spi_eeprom_pkg::status_t status;
    spi_eeprom_pkg::rx_byte_t rx_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int iface_count = 0;

    spi_master_model spi_master_model_inst (.clock(clock), .cs_n(cs_n),
        .sck(sck), .si(si), .hold_n(hold_n));
    spi_eeprom_reset_init #(.powerup_wait_cycles(8))
        spi_eeprom_reset_init_inst (.clock(clock), .resetn(resetn),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .write_busy(write_busy), .wel_set(wel_set), .wel_clear(wel_clear),
        .bp_write(bp_write), .bp_wdata(bp_wdata), .tx_load(tx_load),
        .tx_byte(tx_byte), .so(so), .so_oe(so_oe), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .status(status), .standby(standby),
        .selected(selected), .paused(paused), .iface_reset(iface_reset),
        .powerup_wait_elapsed(powerup_wait_elapsed),
        .erased_value(erased_value));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_sim();
    end
    // collect received bytes and reset pulses
    always @(posedge clock) begin
        if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
        if (iface_reset === 1'b1) iface_count++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] got,
        input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : check

    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // status from its fields: protect, latch, busy
    task automatic check_status(input logic [1:0] bp, input logic w,
        input logic b);
        check("status", 16'(status), {8'h00, 4'h0, bp, w, b});
    endtask : check_status

    task automatic strobe(input int which);
        @(posedge clock) begin
            wel_set <= (which == 0);
            wel_clear <= (which == 1);
            bp_write <= (which == 2);
            tx_load <= (which == 3);
        end
        @(posedge clock) {wel_set, wel_clear, bp_write, tx_load} <= 4'h0;
        @(posedge clock);
    endtask : strobe

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        resetn = 1'b0;
        {write_busy, wel_set, wel_clear, bp_write, tx_load} = 5'h00;
        bp_wdata = 2'h0;
        tx_byte = 8'h00;
        // instruction during reset must be ignored
        spi_master_model_inst.drive_cs(1'b0);
        spi_master_model_inst.send_bits(8'h06, 8);
        spi_master_model_inst.drive_cs(1'b1);
        repeat (20) @(posedge clock);
        check("standby", 16'(standby), 16'h0000);
        check("so_oe", 16'(so_oe), 16'h0000);
        check_status(spi_eeprom_pkg::FACTORY_BLOCK_PROTECT, 0, 0);
        check("erased", 16'(erased_value), 16'h00ff);
        @(posedge clock) resetn <= 1'b1;
        repeat (2) @(posedge clock);
        check("rx count", 16'(rx_q.size()), 16'h0000);
        check("standby", 16'(standby), 16'h0001);
        check("sel pause", {selected, paused}, 16'h0000);
        check_status(2'h0, 0, 0);
        // master waits before the first instruction
        n = 0;
        while (powerup_wait_elapsed !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        check("wait done", 16'(n < 20), 16'h0001);
        // two bytes, output load, then a partial byte dropped
        spi_master_model_inst.drive_cs(1'b0);
        check("selected", 16'(selected), 16'h0001);
        spi_master_model_inst.send_bits(8'ha5, 8);
        spi_master_model_inst.send_bits(8'h3c, 8);
        tx_byte <= 8'h80;
        strobe(3);
        check("so", {so_oe, so}, 16'h0003);
        spi_master_model_inst.send_bits(8'hf0, 4);
        spi_master_model_inst.drive_cs(1'b1);
        check("so_oe off", 16'(so_oe), 16'h0000);
        check("rx count", 16'(rx_q.size()), 16'h0002);
        check("byte 0", 16'(rx_q[0]), 16'h01a5);
        check("byte 1", 16'(rx_q[1]), 16'h003c);
        // clocks while deselected are ignored
        spi_master_model_inst.send_bits(8'h55, 8);
        check("rx idle", 16'(rx_q.size()), 16'h0002);
        // partial frame, then clockless toggle keeps status
        strobe(0);
        spi_master_model_inst.drive_cs(1'b0);
        spi_master_model_inst.send_bits(8'hff, 3);
        spi_master_model_inst.toggle_reset();
        // let the collector count the pulse before looking
        @(posedge clock);
        check("iface reset", 16'(iface_count), 16'h0001);
        check_status(2'h0, 1, 0);
        spi_master_model_inst.drive_cs(1'b0);
        spi_master_model_inst.send_bits(8'h5a, 8);
        spi_master_model_inst.drive_cs(1'b1);
        check("new opcode", 16'(rx_q[2]), 16'h015a);
        // protect write, busy mirror, latch clear
        bp_wdata <= 2'h2;
        strobe(2);
        @(posedge clock) write_busy <= 1'b1;
        repeat (2) @(posedge clock);
        check_status(2'h2, 1, 1);
        strobe(1);
        check_status(2'h2, 0, 1);
        // pause then deselect clears the latch
        strobe(0);
        @(posedge clock) write_busy <= 1'b0;
        spi_master_model_inst.drive_cs(1'b0);
        spi_master_model_inst.set_hold(1'b0);
        check("paused", 16'(paused), 16'h0001);
        spi_master_model_inst.drive_cs(1'b1);
        spi_master_model_inst.set_hold(1'b1);
        check_status(2'h2, 0, 0);
        // second power-on reset: protect bits survive
        strobe(0);
        @(posedge clock) resetn <= 1'b0;
        repeat (3) @(posedge clock);
        @(posedge clock) resetn <= 1'b1;
        repeat (2) @(posedge clock);
        check_status(2'h2, 0, 0);
        check("standby", {standby, paused}, 16'h0002);
        end_sim();
    end
endmodule : spi_eeprom_reset_init_tb
